// [inc/gpio_params.svh]
// register indices, field positions, reset values and override constants of the port block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_A_IN 8'h00
`define IDX_A_DIR 8'h01
`define IDX_A_OUT 8'h02
`define IDX_B_IN 8'h03
`define IDX_B_DIR 8'h04
`define IDX_B_OUT 8'h05
`define IDX_C_IN 8'h06
`define IDX_C_DIR 8'h07
`define IDX_C_OUT 8'h08
`define IDX_D_IN 8'h09
`define IDX_D_DIR 8'h0A
`define IDX_D_OUT 8'h0B
`define IDX_E_DIR 8'h0D
`define IDX_E_OUT 8'h0E
`define IDX_MCU_CTRL 8'h35

// control register layout
`define MCU_PULL_OFF_BIT 4
`define MCU_WR_MASK 8'h93
`define MCU_RST_VAL 8'h00

// port register layout
`define PORT_WIDTH 8
`define PORT_COUNT 5
`define PORT_RST_VAL 8'h00

// lcd port mask thresholds: a pin is taken when the mask exceeds its figure
`define LCD_PM_G4_LIMIT 5
`define LCD_PM_G3_LIMIT 6
`define LCD_PM_G10_LIMIT 0
`define LCD_PM_WIDTH 3

// override values applied while the lcd owns a port g pin
`define PULL_OVR_VAL 1'b0
`define G4_DIR_OVR_VAL 1'b1
`define G_DIR_OVR_VAL 1'b0
`define IN_EN_OVR_VAL 1'b0
`define DRIVE_OVR_VAL 1'b0

`endif

// [inc/gpio_pkg.sv]
// shared types of the port block
package gpio_pkg;
  // bus phase tracker, gray coded along idle -> data
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_DATA = 2'b01} bus_phase_t;
  typedef logic [7:0] port_byte_t;
  typedef logic [7:0] reg_index_t;
endpackage

// [verilog/gpio_port_bits.sv]
// one general-purpose port: direction, output data, input sampling and pull-up
`timescale 1ns/10ps
`include "gpio_params.svh"
module gpio_port_bits #(
  parameter int WIDTH = `PORT_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register writes
  input wire logic wr_dir,
  input wire logic wr_out,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic nxt_pull_off,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] direction_bit,
  output logic [WIDTH-1:0] output_bit,
  output logic [WIDTH-1:0] input_level,
  output logic [WIDTH-1:0] pullup_en
);
  logic [WIDTH-1:0] nxt_dir;
  logic [WIDTH-1:0] nxt_out;

  if (WIDTH < 1 || WIDTH > 8)
    $error("gpio_port_bits: WIDTH must lie in 1..8");

  // next register values from the bus strobes
  assign nxt_dir = wr_dir ? wdata : direction_bit;
  assign nxt_out = wr_out ? wdata : output_bit;

  // registers clear to zero, all pins input
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      direction_bit <= WIDTH'(`PORT_RST_VAL);
      output_bit <= WIDTH'(`PORT_RST_VAL);
    end
    else
    begin
      direction_bit <= nxt_dir;
      output_bit <= nxt_out;
    end
  end

  // pull-up on for input with output bit set, unless globally off
  always_ff @(posedge clk)
  begin
    if (rst)
      pullup_en <= '0;
    else
      pullup_en <= ~nxt_dir & nxt_out & {WIDTH{~nxt_pull_off}};
  end

  // pin level has no reset value; it only follows the pins
  always_ff @(posedge clk)
  begin
    input_level <= pin_in;
  end
endmodule

// [verilog/gpio_port_g_override.sv]
// port g alternate-function override: reset pin, timer count inputs, lcd segments
`timescale 1ns/10ps
`include "gpio_params.svh"
module gpio_port_g_override #(
  parameter int PM_WIDTH = `LCD_PM_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controls
  input wire logic lcd_enable,
  input wire logic [PM_WIDTH-1:0] lcd_port_mask,
  input wire logic reset_pin_disable_fuse,
  input wire logic pull_off,
  input wire logic [4:0] reg_dir,
  input wire logic [4:0] reg_out,
  // pins and segment drivers
  input wire logic [5:0] pin,
  input wire logic [4:0] seg,
  // resolved pin controls
  output logic [4:0] pin_oe,
  output logic [4:0] pin_drive,
  output logic [5:0] pull_en,
  output logic [4:0] input_en,
  output logic [5:0] digital_input_path,
  output logic [4:0] analog_en,
  output logic [4:0] analog_io_path,
  output logic timer0_count_input,
  output logic timer1_count_input,
  output logic ext_reset_n
);
  logic take_g4;
  logic take_g3;
  logic take_g10;
  logic [4:0] ovr_en;
  logic [4:0] dir_ovr_val;
  logic [4:0] nxt_dir;
  logic [4:0] nxt_drive;
  logic [4:0] nxt_pull;
  logic [4:0] nxt_in_en;

  if (PM_WIDTH < 3)
    $error("gpio_port_g_override: PM_WIDTH must hold the value 6");

  // lcd ownership of each pin
  assign take_g4 = lcd_enable && (lcd_port_mask > PM_WIDTH'(`LCD_PM_G4_LIMIT));
  assign take_g3 = lcd_enable && (lcd_port_mask > PM_WIDTH'(`LCD_PM_G3_LIMIT));
  assign take_g10 = lcd_enable && (lcd_port_mask > PM_WIDTH'(`LCD_PM_G10_LIMIT));
  assign ovr_en = {take_g4, take_g3, lcd_enable, take_g10, take_g10};
  assign dir_ovr_val = {`G4_DIR_OVR_VAL, {4{`G_DIR_OVR_VAL}}};

  // override value replaces the register-derived one; port value never overridden
  assign nxt_dir = (ovr_en & dir_ovr_val) | (~ovr_en & reg_dir);
  assign nxt_drive = reg_out;
  // per pin: an override on one pin must not drop the pull-up of another
  assign nxt_pull = (ovr_en & {5{`PULL_OVR_VAL}}) | (~ovr_en & ~reg_dir & reg_out & {5{~pull_off}});
  assign nxt_in_en = (ovr_en & {5{`IN_EN_OVR_VAL}}) | ~ovr_en;

  // resolved pin controls, registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_oe <= '0;
      pin_drive <= '0;
      pull_en <= '0;
      input_en <= '1;
      analog_en <= '0;
      analog_io_path <= '0;
    end
    else
    begin
      pin_oe <= nxt_dir;
      pin_drive <= nxt_drive;
      pull_en <= {reset_pin_disable_fuse, nxt_pull};
      input_en <= nxt_in_en;
      analog_en <= ovr_en;
      analog_io_path <= ovr_en & seg;
    end
  end

  // digital input and its consumers; port g bit 5 is reset until the fuse frees it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      digital_input_path <= '0;
      timer0_count_input <= 1'b0;
      timer1_count_input <= 1'b0;
      ext_reset_n <= 1'b1;
    end
    else
    begin
      digital_input_path <= {pin[5] & reset_pin_disable_fuse, pin[4:0] & nxt_in_en};
      timer0_count_input <= pin[4] & nxt_in_en[4];
      timer1_count_input <= pin[3] & nxt_in_en[3];
      ext_reset_n <= reset_pin_disable_fuse | pin[5];
    end
  end
endmodule

// [verilog/gpio_port_block.sv]
// port registers for ports a to e on an ahb-lite slave, with the port g override
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`include "gpio_params.svh"
module gpio_port_block #(
  parameter int LCD_PM_WIDTH = `LCD_PM_WIDTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // ports a to e
  input wire gpio_pkg::port_byte_t PORT_IN [`PORT_COUNT],
  output gpio_pkg::port_byte_t PORT_DIR [`PORT_COUNT],
  output gpio_pkg::port_byte_t PORT_OUT [`PORT_COUNT],
  output gpio_pkg::port_byte_t PORT_PULL [`PORT_COUNT],
  // port g controls
  input wire logic LCD_ENABLE,
  input wire logic [LCD_PM_WIDTH-1:0] LCD_PORT_MASK,
  input wire logic RESET_PIN_DISABLE_FUSE,
  input wire logic [4:0] G_DIR_REG,
  input wire logic [4:0] G_OUT_REG,
  // port g pins and segment drivers
  input wire logic [5:0] G_PIN,
  input wire logic LCD_SEGMENT_23,
  input wire logic LCD_SEGMENT_24,
  input wire logic LCD_SEGMENT_4,
  input wire logic LCD_SEGMENT_13,
  input wire logic LCD_SEGMENT_14,
  // port g resolved controls
  output logic [4:0] G_OE,
  output logic [4:0] G_DRIVE,
  output logic [5:0] G_PULL,
  output logic [4:0] G_INPUT_ENABLE,
  output logic [5:0] G_DIGITAL_INPUT_PATH,
  output logic [4:0] G_ANALOG_EN,
  output logic [4:0] G_ANALOG_IO_PATH,
  output logic TIMER0_COUNT_INPUT,
  output logic TIMER1_COUNT_INPUT,
  output logic EXT_RESET_N
);
  import gpio_pkg::*;

  // index tables per port; port e has no mapped input-level register
  localparam reg_index_t IN_IDX [`PORT_COUNT] =
    '{`IDX_A_IN, `IDX_B_IN, `IDX_C_IN, `IDX_D_IN, 8'hFF};
  localparam reg_index_t DIR_IDX [`PORT_COUNT] =
    '{`IDX_A_DIR, `IDX_B_DIR, `IDX_C_DIR, `IDX_D_DIR, `IDX_E_DIR};
  localparam reg_index_t OUT_IDX [`PORT_COUNT] =
    '{`IDX_A_OUT, `IDX_B_OUT, `IDX_C_OUT, `IDX_D_OUT, `IDX_E_OUT};
  localparam logic [`PORT_COUNT-1:0] IN_MAPPED = 5'h0F;

  bus_phase_t ph_ff;
  bus_phase_t nxt_ph;
  logic wr_ff;
  reg_index_t idx_ff;
  logic addr_ok_ff;
  port_byte_t mcu_ff;
  port_byte_t nxt_mcu;
  logic nxt_pull_off;
  logic take_req;
  logic wr_now;
  reg_index_t req_idx;
  logic req_addr_ok;
  port_byte_t wbyte;
  port_byte_t level [`PORT_COUNT];
  logic [`PORT_COUNT-1:0] hit_in;
  logic [`PORT_COUNT-1:0] hit_dir;
  logic [`PORT_COUNT-1:0] hit_out;
  logic [`PORT_COUNT-1:0] wr_dir;
  logic [`PORT_COUNT-1:0] wr_out;
  logic hit_mcu;
  logic wr_mcu;
  logic fwd_hit;
  port_byte_t fwd_byte;
  port_byte_t rd_byte;
  port_byte_t rd_final;

  // address phase: taken when selected, nonsequential or sequential and the bus is ready
  assign take_req = HSEL && HTRANS[1] && HREADY;
  assign req_idx = HADDR[9:2];
  // anything beyond the index field or off word alignment is unmapped
  assign req_addr_ok = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);
  assign nxt_ph = take_req ? PH_DATA : PH_IDLE;

  // address phase capture
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ph_ff <= PH_IDLE;
      wr_ff <= 1'b0;
      idx_ff <= '0;
      addr_ok_ff <= 1'b0;
    end
    else
    begin
      ph_ff <= nxt_ph;
      wr_ff <= take_req && HWRITE;
      idx_ff <= req_idx;
      addr_ok_ff <= req_addr_ok;
    end
  end

  // data phase write strobes; word-wide transfers carry the byte in the low lane
  assign wr_now = (ph_ff == PH_DATA) && wr_ff && addr_ok_ff;
  assign wbyte = HWDATA[7:0];
  assign hit_mcu = (idx_ff == `IDX_MCU_CTRL);
  assign wr_mcu = wr_now && hit_mcu;

  // control register: only the writable bits take data, the rest stay zero
  assign nxt_mcu = wr_mcu ? (wbyte & `MCU_WR_MASK) : mcu_ff;
  assign nxt_pull_off = nxt_mcu[`MCU_PULL_OFF_BIT];

  always_ff @(posedge CLK)
  begin
    if (RST)
      mcu_ff <= `MCU_RST_VAL;
    else
      mcu_ff <= nxt_mcu;
  end

  // one port instance per port, each decoded against its own indices
  for (genvar p = 0; p < `PORT_COUNT; p++)
  begin : g_port
    assign hit_in[p] = IN_MAPPED[p] && (idx_ff == IN_IDX[p]);
    assign hit_dir[p] = (idx_ff == DIR_IDX[p]);
    assign hit_out[p] = (idx_ff == OUT_IDX[p]);
    assign wr_dir[p] = wr_now && hit_dir[p];
    assign wr_out[p] = wr_now && hit_out[p];

    gpio_port_bits #(
      .WIDTH(`PORT_WIDTH)
    ) u_port (
      .clk(CLK),
      .rst(RST),
      .wr_dir(wr_dir[p]),
      .wr_out(wr_out[p]),
      .wdata(wbyte),
      .nxt_pull_off(nxt_pull_off),
      .pin_in(PORT_IN[p]),
      .direction_bit(PORT_DIR[p]),
      .output_bit(PORT_OUT[p]),
      .input_level(level[p]),
      .pullup_en(PORT_PULL[p])
    );
  end

  // read mux for the address phase index; unmapped reads return zero
  always_comb
  begin
    rd_byte = '0;
    if (!req_addr_ok)
      rd_byte = '0;
    else if (req_idx == `IDX_MCU_CTRL)
      rd_byte = mcu_ff;
    else
    begin
      for (int p = 0; p < `PORT_COUNT; p++)
      begin
        if (IN_MAPPED[p] && req_idx == IN_IDX[p])
          rd_byte = level[p];
        else if (req_idx == DIR_IDX[p])
          rd_byte = PORT_DIR[p];
        else if (req_idx == OUT_IDX[p])
          rd_byte = PORT_OUT[p];
      end
    end
  end

  // a read right behind a write to the same register sees the new value;
  // input-level writes are dropped, so they forward nothing
  assign fwd_hit = wr_now && take_req && req_addr_ok && (req_idx == idx_ff) &&
    ((|hit_dir) || (|hit_out) || hit_mcu);
  assign fwd_byte = hit_mcu ? (wbyte & `MCU_WR_MASK) : wbyte;
  assign rd_final = fwd_hit ? fwd_byte : rd_byte;

  // zero wait states: read data sits in a register for the data phase
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      HRDATA <= {24'h000000, (take_req && !HWRITE) ? rd_final : 8'h00};
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // port g pin override logic
  gpio_port_g_override #(
    .PM_WIDTH(LCD_PM_WIDTH)
  ) u_port_g (
    .clk(CLK),
    .rst(RST),
    .lcd_enable(LCD_ENABLE),
    .lcd_port_mask(LCD_PORT_MASK),
    .reset_pin_disable_fuse(RESET_PIN_DISABLE_FUSE),
    .pull_off(nxt_pull_off), // same edge as the port a to e pull-ups
    .reg_dir(G_DIR_REG),
    .reg_out(G_OUT_REG),
    .pin(G_PIN),
    .seg({LCD_SEGMENT_23, LCD_SEGMENT_24, LCD_SEGMENT_4, LCD_SEGMENT_13, LCD_SEGMENT_14}),
    .pin_oe(G_OE),
    .pin_drive(G_DRIVE),
    .pull_en(G_PULL),
    .input_en(G_INPUT_ENABLE),
    .digital_input_path(G_DIGITAL_INPUT_PATH),
    .analog_en(G_ANALOG_EN),
    .analog_io_path(G_ANALOG_IO_PATH),
    .timer0_count_input(TIMER0_COUNT_INPUT),
    .timer1_count_input(TIMER1_COUNT_INPUT),
    .ext_reset_n(EXT_RESET_N)
  );

  // helper terms that only the checks read
  logic any_pull;
  logic g4_taken;
  logic g3_taken;
  logic g10_taken;
  logic rd_a_in;
  logic wr_a_dir;
  logic wr_c_out;
  always_comb
  begin
    any_pull = 1'b0;
    for (int p = 0; p < `PORT_COUNT; p++)
      any_pull = any_pull | (|PORT_PULL[p]);
  end
  assign g4_taken = LCD_ENABLE && (LCD_PORT_MASK > LCD_PM_WIDTH'(`LCD_PM_G4_LIMIT));
  assign g3_taken = LCD_ENABLE && (LCD_PORT_MASK > LCD_PM_WIDTH'(`LCD_PM_G3_LIMIT));
  assign g10_taken = LCD_ENABLE && (LCD_PORT_MASK > LCD_PM_WIDTH'(`LCD_PM_G10_LIMIT));
  assign rd_a_in = take_req && !HWRITE && req_addr_ok && (req_idx == `IDX_A_IN);
  assign wr_a_dir = take_req && HWRITE && req_addr_ok && (req_idx == `IDX_A_DIR);
  assign wr_c_out = take_req && HWRITE && req_addr_ok && (req_idx == `IDX_C_OUT);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_global_pull_off: assert property (mcu_ff[`MCU_PULL_OFF_BIT] |->
    !any_pull && G_PULL[4:0] == 5'h00)
    else $error("pull-up active while global disable set");
  a_fuse_reset_pin: assert property (RESET_PIN_DISABLE_FUSE |=> G_PULL[5] && EXT_RESET_N &&
    G_DIGITAL_INPUT_PATH[5] == $past(G_PIN[5]))
    else $error("port g bit 5 not a pulled-up input with fuse programmed");
  a_g4_lcd: assert property (g4_taken |=> G_OE[4] && !G_PULL[4] && !G_INPUT_ENABLE[4] &&
    G_DRIVE[4] == $past(G_OUT_REG[4]))
    else $error("pg4 lcd override wrong");
  a_g3_lcd: assert property (g3_taken |=> !G_OE[3] && !G_PULL[3] && !G_INPUT_ENABLE[3])
    else $error("pg3 lcd override wrong");
  a_g2_lcd: assert property (LCD_ENABLE |=> !G_OE[2] && !G_PULL[2] && !G_INPUT_ENABLE[2] &&
    G_ANALOG_IO_PATH[2] == $past(LCD_SEGMENT_4))
    else $error("pg2 lcd override wrong");
  a_g10_lcd: assert property (g10_taken |=> G_OE[1:0] == 2'h0 && G_PULL[1:0] == 2'h0 &&
    G_INPUT_ENABLE[1:0] == 2'h0)
    else $error("pg1/pg0 lcd override wrong");
  a_timer0_src: assert property (!g4_taken |=> TIMER0_COUNT_INPUT == $past(G_PIN[4]))
    else $error("timer 0 count input not from pg4");
  a_timer1_src: assert property (g3_taken |=> !TIMER1_COUNT_INPUT)
    else $error("timer 1 count input not gated by override");
  a_lcd_segment_23_path: assert property (g4_taken |=> G_ANALOG_EN[4] &&
    G_ANALOG_IO_PATH[4] == $past(LCD_SEGMENT_23))
    else $error("segment 23 not on pg4");
  a_lcd_segment_24_path: assert property (g3_taken |=>
    G_ANALOG_IO_PATH[3] == $past(LCD_SEGMENT_24))
    else $error("segment 24 not on pg3");
  a_lcd_segment_13_path: assert property (!g10_taken |=> !G_ANALOG_EN[1] && !G_ANALOG_IO_PATH[1])
    else $error("segment 13 on pg1 without override");
  a_dir_write: assert property (wr_a_dir ##1 HREADY |=> PORT_DIR[0] == $past(HWDATA[7:0]))
    else $error("direction register a did not take write");
  a_out_write: assert property (wr_c_out ##1 HREADY |=> PORT_OUT[2] == $past(HWDATA[7:0]))
    else $error("output register c did not take write");
  a_level_read: assert property (rd_a_in |=> HRDATA[7:0] == $past(PORT_IN[0], 2))
    else $error("input level read not the sampled pins");
  a_mcu_ro_zero: assert property (##1 (mcu_ff & ~(`MCU_WR_MASK)) == 8'h00)
    else $error("read-only control bits not zero");
  a_reset_clear: assert property (disable iff (1'b0) $past(RST) |->
    PORT_DIR[3] == 8'h00 && PORT_OUT[4] == 8'h00 && mcu_ff == 8'h00)
    else $error("registers not cleared by reset");
  a_ovr_subst: assert property (!LCD_ENABLE |=> G_OE == $past(G_DIR_REG))
    else $error("register direction not used without override");

  c_dir_write: cover property (wr_a_dir ##1 HREADY);
  c_level_read: cover property (rd_a_in);
  c_lcd_g4: cover property (g4_taken ##1 G_OE[4]);
  c_pull_off_set: cover property ($rose(mcu_ff[`MCU_PULL_OFF_BIT]));
endmodule

// [tb/gpio_pin_model.sv]
// board-side model of the port pads: a pad the device drives shows its own value
`timescale 1ns/10ps
`include "gpio_params.svh"
module gpio_pin_model (
  // ports a to e
  input wire gpio_pkg::port_byte_t dir [`PORT_COUNT],
  input wire gpio_pkg::port_byte_t drv [`PORT_COUNT],
  input wire gpio_pkg::port_byte_t ext [`PORT_COUNT],
  output gpio_pkg::port_byte_t level [`PORT_COUNT],
  // port g
  input wire logic [4:0] g_oe,
  input wire logic [4:0] g_drv,
  input wire logic [5:0] g_ext,
  output logic [5:0] g_level
);
  import gpio_pkg::*;
  // input pads show the board level; no pull-up here so a stuck pull is not hidden
  always_comb
    for (int i = 0; i < `PORT_COUNT; i++)
      level[i] = (dir[i] & drv[i]) | (~dir[i] & ext[i]);
  // port g bit 5 is input only, so it always shows the board level
  assign g_level = {g_ext[5], (g_oe & g_drv) | (~g_oe & g_ext[4:0])};
endmodule

// [tb/test_io_port_registers_and_pin_override.sv]
// self-checking bench for the port registers and the port g override
`timescale 1ns/10ps
`include "gpio_params.svh"
module test_io_port_registers_and_pin_override;
  import gpio_pkg::*;
  typedef struct packed {logic [31:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_t;
  logic clk = 1'b0;
  logic rst, hsel, hwrite, hreadyout, hresp, lcd_en, fuse, tmr0_count, tmr1_count, ext_rst_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, lcd_pm;
  logic [4:0] g_dir, g_out, segs, take, oe, gpin, ie, g_oe, g_drive, g_ie, g_aen, g_apath;
  logic [5:0] g_ext, g_pin, g_pull, g_dpath;
  wire hready;
  port_byte_t port_in [`PORT_COUNT], port_dir [`PORT_COUNT], port_out [`PORT_COUNT];
  port_byte_t port_pull [`PORT_COUNT], ext [`PORT_COUNT];
  int n_fail = 0;
  int samples_checked = 0;
  // write then read back; board level of every port is C3
  row_t rows [17] = '{
    '{32'h04, 8'hA5, 8'hA5}, '{32'h08, 8'h3C, 8'h3C}, '{32'h00, 8'hFF, 8'h66},
    '{32'h10, 8'h0F, 8'h0F}, '{32'h14, 8'hF0, 8'hF0}, '{32'h0C, 8'h00, 8'hC0},
    '{32'h1C, 8'h81, 8'h81}, '{32'h20, 8'h7E, 8'h7E}, '{32'h18, 8'hFF, 8'h42},
    '{32'h28, 8'hFF, 8'hFF}, '{32'h2C, 8'h5A, 8'h5A}, '{32'h24, 8'h00, 8'h5A},
    '{32'h34, 8'h55, 8'h55}, '{32'h38, 8'hAA, 8'hAA}, '{32'hD4, 8'hFF, 8'h93},
    '{32'h30, 8'hFF, 8'h00}, '{32'h3C, 8'hFF, 8'h00}};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #5 clk = ~clk;

  gpio_port_block u_dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PORT_IN(port_in), .PORT_DIR(port_dir),
    .PORT_OUT(port_out), .PORT_PULL(port_pull), .LCD_ENABLE(lcd_en), .LCD_PORT_MASK(lcd_pm),
    .RESET_PIN_DISABLE_FUSE(fuse), .G_DIR_REG(g_dir), .G_OUT_REG(g_out), .G_PIN(g_pin),
    .LCD_SEGMENT_23(segs[4]), .LCD_SEGMENT_24(segs[3]), .LCD_SEGMENT_4(segs[2]),
    .LCD_SEGMENT_13(segs[1]), .LCD_SEGMENT_14(segs[0]), .G_OE(g_oe), .G_DRIVE(g_drive),
    .G_PULL(g_pull), .G_INPUT_ENABLE(g_ie), .G_DIGITAL_INPUT_PATH(g_dpath),
    .G_ANALOG_EN(g_aen), .G_ANALOG_IO_PATH(g_apath), .TIMER0_COUNT_INPUT(tmr0_count),
    .TIMER1_COUNT_INPUT(tmr1_count), .EXT_RESET_N(ext_rst_n));

  gpio_pin_model u_pins (.dir(port_dir), .drv(port_out), .ext(ext), .level(port_in),
    .g_oe(g_oe), .g_drv(g_drive), .g_ext(g_ext), .g_level(g_pin));

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // bounded wait for ready; a hung slave ends the run with a fail instead of hanging the simulation
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] %0t bus wait ran out", $time);
      report_and_stop();
    end
  endtask

  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    q = hrdata;
  endtask

  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    lcd_en = 1'b0;
    lcd_pm = 3'h0;
    fuse = 1'b1;
    g_dir = 5'h0A;
    g_out = 5'h1B;
    segs = 5'h16;
    g_ext = 6'h25;
    ext = '{default: 8'hC3};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[r])
    begin
      bus(rows[r].addr, 1'b1, {24'h0, rows[r].wdata}, rd);
      bus(rows[r].addr, 1'b0, 32'h0, rd);
      check(rd, {24'h0, rows[r].rdata}, "register row");
    end
    $display("test registers done");
    // control still holds the pull-up disable from the table
    #1;
    check(port_pull[1], 8'h00, "pull disabled");
    @(posedge clk);
    bus(32'hD4, 1'b1, 32'h0, rd);
    #1;
    check(port_pull[1], 8'hF0, "pull enabled");
    @(posedge clk);
    $display("test pull-up disable done");
    // every lcd enable and mask value, with register settings and segments varied
    for (int i = 0; i < 16; i++)
    begin
      lcd_en <= i[3];
      lcd_pm <= i[2:0];
      g_dir <= 5'h0A ^ {5{i[0]}};
      g_out <= 5'h1B ^ {5{i[1]}};
      segs <= 5'h16 ^ {5{i[2]}};
      repeat (3) @(posedge clk);
      #1;
      take = {i[3] && i[2:0] > 5, i[3] && i[2:0] > 6, i[3], i[3] && i[2:0] > 0,
        i[3] && i[2:0] > 0};
      oe = (g_dir & ~take) | (take & 5'h10);
      ie = ~take;
      gpin = (oe & g_out) | (~oe & g_ext[4:0]);
      check({g_oe, g_pull[4:0], g_ie, g_aen,
        g_apath, g_drive, g_dpath[4:0], tmr0_count, tmr1_count},
        {oe, ~g_dir & g_out & ie, ie, take, segs & take, g_out, gpin & ie, gpin[4] & ie[4],
        gpin[3] & ie[3]}, "port g override");
      @(posedge clk);
    end
    $display("test port g override done");
    for (int i = 0; i < 4; i++)
    begin
      fuse <= i[1];
      g_ext[5] <= i[0];
      repeat (2) @(posedge clk);
      #1;
      check({g_pull[5], g_dpath[5], ext_rst_n}, {i[1], i[1] & i[0], i[1] | i[0]},
        "reset pin");
      @(posedge clk);
    end
    $display("test reset pin done");
    // reset in mid-run with registers loaded and the lcd holding port g bits 0 to 4
    rst <= 1'b1;
    @(posedge clk);
    #1;
    for (int p = 0; p < `PORT_COUNT; p++)
      check({port_dir[p], port_out[p]}, 16'h0000, "reset port regs");
    check({g_ie, ext_rst_n, hresp, hreadyout, hrdata}, {5'h1F, 1'b1, 1'b0, 1'b1, 32'h0},
      "reset outputs");
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(32'hD4, 1'b0, 32'h0, rd);
    check(rd, 32'h0, "control after reset");
    bus(32'h04, 1'b0, 32'h0, rd);
    check(rd, 32'h0, "direction after reset");
    $display("test reset done");
    report_and_stop();
  end
endmodule
